// ### dv/rtcsp_checker.sv
`timescale 1ns/1ns
module rtcsp_checker (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // two-wire bus
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic sdaDevOe,
  input  wire logic sdaHostOe
);
  logic [7:0] lowCnt;

  // cycles since scl was last seen high
  always_ff @(posedge clk_sys) begin
    if (!rst_n || scl) begin
      lowCnt <= 8'h00;
    end else if (lowCnt != 8'hff) begin
      lowCnt <= lowCnt + 8'h01;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence startSeq;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stopSeq;
    scl && $past(scl) && $rose(sda);
  endsequence

  AST_PULL_WITH_SCL_LOW: assert property ($rose(sdaDevOe) |-> !scl)
    else $error("device pulled sda while scl high");
  AST_RELEASE_WITH_SCL_LOW: assert property ($fell(sdaDevOe) |-> !scl)
    else $error("device released sda while scl high");
  AST_DEV_TURNAROUND: assert property ($changed(sdaDevOe) |-> lowCnt inside {[1:6]})
    else $error("device sda change not shortly after scl fall");
  AST_ACK_HELD_HIGH: assert property ($rose(scl) && sdaDevOe |-> sdaDevOe [*8])
    else $error("device drive dropped during scl high");
  AST_QUIET_AFTER_START: assert property (startSeq |-> (!sdaDevOe) [*8])
    else $error("device drives sda right after start");
  AST_RELEASED_AFTER_STOP: assert property (stopSeq |=> (!sdaDevOe) [*8])
    else $error("device drives sda after stop");
  AST_CLOCK_AFTER_START: assert property (startSeq |-> ##[1:40] !scl)
    else $error("no clock pulse after start");
  AST_IDLE_AFTER_STOP: assert property (stopSeq |=> scl && sda)
    else $error("bus not idle after stop");
  AST_HOST_STABLE_HIGH: assert property ($rose(scl) |-> $stable(sdaHostOe) [*6])
    else $error("host sda changed while scl high");
endmodule : rtcsp_checker

// ### dv/tb_clock_calendar_registers_two_wire_slave_port.sv
`timescale 1ns/1ns
module tb_clock_calendar_registers_two_wire_slave_port;
  import rtcsp_pkg::*;
  localparam logic [4:0] C_S = 5'(1 << CMD_START);
  localparam logic [4:0] C_W = 5'(1 << CMD_WRITE);
  localparam logic [4:0] C_R = 5'(1 << CMD_READ);
  localparam logic [4:0] C_P = 5'(1 << CMD_STOP);
  localparam logic [4:0] C_N = 5'(1 << CMD_NACK_LAST);
  logic        clk_sys;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        backupPower;
  logic        eepromBusy;
  logic        wrStrobe;
  logic        wrClockSpace;
  logic [7:0]  wrAddr;
  logic [7:0]  wrData;
  logic [7:0]  lastRx;
  logic [15:0] rdv;
  logic [31:0] q;
  logic        e;
  int          err_total;
  int          num_checks;
  int          wrCount;
  logic [16:0] rangeTab [8];

  rtcsp_bus_if busLink ();
  rtcsp_host u_rtcsp_host (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(busLink));
  rtcsp_device u_rtcsp_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(busLink),
    .backupPower(backupPower), .eepromBusy(eepromBusy), .wrStrobe(wrStrobe),
    .wrClockSpace(wrClockSpace), .wrAddr(wrAddr), .wrData(wrData));
  rtcsp_checker u_rtcsp_checker (.clk_sys(clk_sys), .rst_n(rst_n), .scl(busLink.scl),
    .sda(busLink.sda), .sdaDevOe(busLink.sdaDevOe), .sdaHostOe(busLink.sdaHostOe));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (wrStrobe === 1'b1) begin
      wrCount++;
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic step(input logic [4:0] cmd, input logic [7:0] b, input logic expNack);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, TX_OFF, {24'h0, b}, rd, err);
    apb(1'b1, CMD_OFF, {27'h0, cmd}, rd, err);
    rd = 32'h1;
    while (rd[STAT_BUSY] !== 1'b0) begin
      apb(1'b0, STAT_OFF, 32'h0, rd, err);
    end
    if (cmd[CMD_WRITE]) begin
      check({31'h0, rd[STAT_NACK]}, {31'h0, expNack});
    end
    apb(1'b0, RX_OFF, 32'h0, rd, err);
    lastRx = rd[7:0];
  endtask : step

  task automatic rdAt(input logic [7:0] ctl, input logic [7:0] a, output logic [15:0] v);
    step(C_S | C_W, ctl, 1'b0);
    step(C_W, a, 1'b0);
    step(C_S | C_W, ctl | 8'h01, 1'b0);
    step(C_R, 8'h00, 1'b0);
    v[15:8] = lastRx;
    step(C_R | C_N | C_P, 8'h00, 1'b0);
    v[7:0] = lastRx;
  endtask : rdAt

  initial begin
    repeat (80000) @(posedge clk_sys);
    err_total++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    backupPower = 1'b0;
    eepromBusy = 1'b0;
    err_total = 0;
    num_checks = 0;
    wrCount = 0;
    rangeTab = '{{8'hde, 8'h5f, 1'b0}, {8'hde, 8'h60, 1'b1}, {8'hae, 8'h7f, 1'b0},
                 {8'hae, 8'h80, 1'b1}, {8'hae, 8'hf0, 1'b0}, {8'hae, 8'hf7, 1'b0},
                 {8'hae, 8'hf8, 1'b1}, {8'hae, 8'hff, 1'b0}};
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    // reset state and unmapped register
    apb(1'b0, STAT_OFF, 32'h0, q, e);
    check(q, 32'h0);
    apb(1'b0, 8'h10, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    // clock-space write of two sram bytes
    step(C_S | C_W, 8'hde, 1'b0);
    step(C_W, SRAM_FIRST, 1'b0);
    step(C_W, 8'ha5, 1'b0);
    step(C_W | C_P, 8'h5a, 1'b0);
    check({15'h0, wrClockSpace, wrAddr, wrData}, {15'h0, 1'b1, 8'h21, 8'h5a});
    check(32'(wrCount), 32'h2);
    rdAt(8'hde, SRAM_FIRST, rdv);
    check({16'h0, rdv}, 32'h0000a55a);
    // wrong codes or chip-select bits
    foreach (rangeTab[i]) begin
      step(C_S | C_W, 8'hde ^ 8'(2 << (i % 7)), 1'b1);
      step(C_P, 8'h00, 1'b0);
    end
    step(C_S | C_W, 8'h9e, 1'b1);
    step(C_P, 8'h00, 1'b0);
    // programming in progress
    eepromBusy <= 1'b1;
    step(C_S | C_W, 8'hae, 1'b1);
    step(C_P, 8'h00, 1'b0);
    step(C_S | C_W | C_P, 8'hde, 1'b0);
    eepromBusy <= 1'b0;
    // word address ranges of both spaces
    foreach (rangeTab[i]) begin
      step(C_S | C_W, rangeTab[i][16:9], 1'b0);
      step(C_W | C_P, rangeTab[i][8:1], rangeTab[i][0]);
    end
    // protection status byte, then read past sram end
    step(C_S | C_W, 8'hae, 1'b0);
    step(C_W, PROTECT_STATUS_ADDR, 1'b0);
    step(C_W | C_P, 8'h3c, 1'b0);
    check({15'h0, wrClockSpace, wrAddr, wrData}, {15'h0, 1'b0, 8'hff, 8'h3c});
    rdAt(8'hae, PROTECT_STATUS_ADDR, rdv);
    check({16'h0, rdv}, {16'h0, 8'h3c, 8'h00});
    rdAt(8'hde, SRAM_LAST, rdv);
    check({16'h0, rdv}, {16'h0, 8'h00, UNMAPPED_READ});
    // backup supply
    backupPower <= 1'b1;
    step(C_S | C_W, 8'hde, 1'b1);
    step(C_P, 8'h00, 1'b0);
    backupPower <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rdAt(8'hde, SRAM_FIRST, rdv);
    check({16'h0, rdv}, 32'h0000a55a);
    check(32'(wrCount), 32'h3);
    complete_run();
  end
endmodule : tb_clock_calendar_registers_two_wire_slave_port

// ### verilog/rtcsp_bus_if.sv
`timescale 1ns/1ns
interface rtcsp_bus_if;
  logic scl;
  logic sdaDevOut;
  logic sdaDevOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sda;

  // open-drain wired-and with pull-up
  assign sda = ~((sdaDevOe & ~sdaDevOut) | (sdaHostOe & ~sdaHostOut));

  modport device (input scl, input sda, output sdaDevOut, output sdaDevOe);
  modport host (output scl, input sda, output sdaHostOut, output sdaHostOe);
endinterface : rtcsp_bus_if

// ### verilog/rtcsp_device.sv
`timescale 1ns/1ns
// Behaviour
// [RULE1] device is slave only, never drives scl
// [RULE2] master starts only on idle bus
// [RULE3] sda change with scl high is condition
// [RULE4] start is sda fall, scl high
// [RULE5] stop is sda rise, scl high, ends transfer
// [RULE6] master ends every operation with stop
// [RULE7] one bit per clock, change low, sample high
// [RULE8] master sets byte count, no fixed length
// [RULE9] receiver acks every byte, master clocks it
// [RULE10] ack holds sda low through high period
// [RULE11] master nack ends read, slave releases sda
// [RULE12] eeprom control byte refused while programming
// [RULE13] interface dead while on backup supply
// [RULE14] first byte is control, codes 1010/1101
// [RULE15] chip-select bits always all ones
// [RULE16] control lsb one reads, zero writes
// [RULE17] ack matching address, then read or write
// [RULE18] two spaces: clock/sram and eeprom
// [RULE19] out-of-range word address is not acked
// [RULE20] clock regs 00-1f, sram 20-5f
// [RULE21] eeprom 00-7f, protected f0-f7, status ff
// [RULE22] clock and sram kept on backup power
module rtcsp_device
  import rtcsp_pkg::*;
(
  // system
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // two-wire bus
  rtcsp_bus_if.device      link,
  // power and memory status
  input  wire logic        backupPower,
  input  wire logic        eepromBusy,
  // write notification
  output logic             wrStrobe,
  output logic             wrClockSpace,
  output logic [7:0]       wrAddr,
  output logic [7:0]       wrData
);

  typedef struct packed {
    rtcsp_dev_state_type                     state;
    rtcsp_dev_state_type                     after;
    logic                                    sclMeta;
    logic                                    sclSync;
    logic                                    sclPrev;
    logic                                    sdaMeta;
    logic                                    sdaSync;
    logic                                    sdaPrev;
    logic [3:0]                              cnt;
    logic [7:0]                              sh;
    logic                                    clockSpace;
    logic [7:0]                              ptr;
    logic                                    ackd;
    logic                                    sdaOe;
    logic                                    wrStrobe;
    logic                                    wrClockSpace;
    logic [7:0]                              wrAddr;
    logic [7:0]                              wrData;
    logic [CLOCK_SPACE_BYTES-1:0][7:0]       clockMem;
    logic [EEPROM_SPACE_BYTES-1:0][7:0]      eeMem;
  } rtcsp_dev_type;

  rtcsp_dev_type st;
  rtcsp_dev_type next_st;
  logic          sclRise;
  logic          sclFall;
  logic          startSeen;
  logic          stopSeen;
  logic          ack;
  logic          loadRead;
  logic [7:0]    rdData;

  // word address present in the selected space
  function automatic logic inRange(input logic clockSpace, input logic [7:0] a);
    if (clockSpace) begin
      inRange = (a <= SRAM_LAST); // RULE20
    end else begin
      inRange = (a <= EEPROM_LAST) || ((a >= PROT_FIRST) && (a <= PROT_LAST))
                || (a == PROTECT_STATUS_ADDR); // RULE21
    end
  endfunction : inRange

  // eeprom space address to storage index
  function automatic logic [7:0] eeIndex(input logic [7:0] a);
    if (a <= EEPROM_LAST) begin
      eeIndex = a;
    end else if (a == PROTECT_STATUS_ADDR) begin
      eeIndex = STATUS_INDEX;
    end else begin
      eeIndex = PROT_INDEX + {5'h00, a[2:0]};
    end
  endfunction : eeIndex

  always_comb begin
    next_st = st;
    // two-stage synchronisers on the pins
    next_st.sclMeta = link.scl; // RULE1
    next_st.sclSync = st.sclMeta;
    next_st.sclPrev = st.sclSync;
    next_st.sdaMeta = link.sda;
    next_st.sdaSync = st.sdaMeta;
    next_st.sdaPrev = st.sdaSync;
    next_st.wrStrobe = 1'b0;
    sclRise = st.sclSync & ~st.sclPrev;
    sclFall = ~st.sclSync & st.sclPrev;
    startSeen = st.sclSync & st.sclPrev & st.sdaPrev & ~st.sdaSync; // RULE3 RULE4
    stopSeen = st.sclSync & st.sclPrev & ~st.sdaPrev & st.sdaSync; // RULE3 RULE5
    ack = 1'b0;
    loadRead = 1'b0;
    rdData = UNMAPPED_READ;
    if (st.clockSpace) begin
      if (inRange(1'b1, st.ptr)) begin
        rdData = st.clockMem[st.ptr[6:0]];
      end
    end else if (inRange(1'b0, st.ptr)) begin
      rdData = st.eeMem[eeIndex(st.ptr)];
    end
    if (backupPower) begin
      next_st.state = D_IDLE; // RULE13
      next_st.sdaOe = 1'b0;
    end else if (startSeen) begin
      next_st.state = D_CTRL; // RULE4 RULE14
      next_st.cnt = 4'h0;
      next_st.sdaOe = 1'b0;
    end else if (stopSeen) begin
      next_st.state = D_IDLE; // RULE5
      next_st.sdaOe = 1'b0;
    end else begin
      case (st.state)
        D_CTRL, D_ADDR, D_WDATA: begin
          if (sclRise) begin
            next_st.sh = {st.sh[6:0], st.sdaSync}; // RULE7
            next_st.cnt = st.cnt + 4'h1;
          end else if (sclFall && (st.cnt == BYTE_BITS)) begin
            next_st.cnt = 4'h0;
            case (st.state)
              D_CTRL: begin
                if (st.sh[7:1] == {CODE_CLOCK, CHIP_SELECT}) begin // RULE15 RULE18
                  ack = 1'b1;
                  next_st.clockSpace = 1'b1;
                end else if ((st.sh[7:1] == {CODE_EEPROM, CHIP_SELECT}) && !eepromBusy) begin
                  ack = 1'b1; // RULE12
                  next_st.clockSpace = 1'b0;
                end
                next_st.after = st.sh[0] ? D_RDATA : D_ADDR; // RULE16 RULE17
              end
              D_ADDR: begin
                ack = inRange(st.clockSpace, st.sh); // RULE19
                next_st.ptr = st.sh;
                next_st.after = D_WDATA;
              end
              default: begin
                ack = inRange(st.clockSpace, st.ptr); // RULE19
                next_st.after = D_WDATA; // RULE8
                if (ack) begin
                  if (st.clockSpace) begin
                    next_st.clockMem[st.ptr[6:0]] = st.sh;
                  end else begin
                    next_st.eeMem[eeIndex(st.ptr)] = st.sh;
                  end
                  next_st.ptr = st.ptr + 8'h01;
                  next_st.wrStrobe = 1'b1;
                  next_st.wrClockSpace = st.clockSpace;
                  next_st.wrAddr = st.ptr;
                  next_st.wrData = st.sh;
                end
              end
            endcase
            next_st.sdaOe = ack; // RULE9 RULE10
            next_st.state = ack ? D_ACK : D_IGNORE;
          end
        end
        D_ACK: begin
          if (sclFall) begin
            next_st.sdaOe = 1'b0; // RULE10
            next_st.state = st.after;
            loadRead = (st.after == D_RDATA);
          end
        end
        D_RDATA: begin
          if (sclRise) begin
            next_st.cnt = st.cnt + 4'h1; // RULE7
          end else if (sclFall) begin
            if (st.cnt == BYTE_BITS) begin
              next_st.sdaOe = 1'b0;
              next_st.state = D_MACK;
            end else begin
              next_st.sh = {st.sh[6:0], 1'b0}; // RULE7
              next_st.sdaOe = ~st.sh[6];
            end
          end
        end
        D_MACK: begin
          if (sclRise) begin
            next_st.ackd = ~st.sdaSync;
          end else if (sclFall) begin
            if (st.ackd) begin
              loadRead = 1'b1; // RULE8
            end else begin
              next_st.state = D_IGNORE; // RULE11
            end
          end
        end
        D_IDLE, D_IGNORE: begin
          next_st.sdaOe = 1'b0;
        end
        default: begin
          next_st.state = D_IDLE;
          next_st.sdaOe = 1'b0;
        end
      endcase
      if (loadRead) begin
        next_st.sh = rdData;
        next_st.ptr = st.ptr + 8'h01;
        next_st.cnt = 4'h0;
        next_st.sdaOe = ~rdData[7];
        next_st.state = D_RDATA;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st; // RULE22
    end
  end

  assign link.sdaDevOut = DRIVE_LOW;
  assign link.sdaDevOe = st.sdaOe;
  assign wrStrobe = st.wrStrobe;
  assign wrClockSpace = st.wrClockSpace;
  assign wrAddr = st.wrAddr;
  assign wrData = st.wrData;
endmodule : rtcsp_device

// ### verilog/rtcsp_host.sv
`timescale 1ns/1ns
module rtcsp_host
  import rtcsp_pkg::*;
(
  // system
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // two-wire bus
  rtcsp_bus_if.host        link
);

  typedef struct packed {
    rtcsp_host_phase_type phase;
    logic [2:0]           tick;
    logic [1:0]           q;
    logic [3:0]           bitIdx;
    logic [3:0]           pend;
    logic                 nackLast;
    logic                 rd;
    logic [7:0]           tx;
    logic [7:0]           txShift;
    logic [7:0]           rx;
    logic                 nack;
    logic                 busy;
    logic                 scl;
    logic                 sdaOe;
    logic                 sdaMeta;
    logic                 sdaSync;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
  } rtcsp_host_type;

  rtcsp_host_type st;
  rtcsp_host_type next_st;
  logic           bitVal;
  logic [1:0]     nq;

  always_comb begin
    next_st = st;
    next_st.sdaMeta = link.sda;
    next_st.sdaSync = st.sdaMeta;
    next_st.pready = 1'b0;
    nq = st.q + 2'h1;
    // bit to put on sda for the current step
    if (st.phase == H_START) begin
      bitVal = (nq == Q_LOW_SET); // RULE4
    end else if (st.phase == H_STOP) begin
      bitVal = (nq == Q_HIGH_SET); // RULE5 RULE6
    end else if (st.bitIdx == BYTE_BITS) begin
      bitVal = ~st.rd | st.nackLast; // RULE9 RULE11
    end else begin
      bitVal = st.rd | st.txShift[7];
    end
    // apb setup cycle prepares a one-cycle answer
    if (psel && !penable && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.pslverr = 1'b0;
      next_st.prdata = '0;
      case (paddr)
        CMD_OFF: next_st.prdata[CMD_NACK_LAST:0] = {st.nackLast, st.pend};
        TX_OFF: next_st.prdata[7:0] = st.tx;
        RX_OFF: next_st.prdata[7:0] = st.rx;
        STAT_OFF: next_st.prdata[STAT_NACK:0] = {st.nack, st.busy};
        default: next_st.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && st.pready && pwrite) begin
      if (paddr == CMD_OFF && !st.busy) begin
        next_st.pend = pwdata[CMD_STOP:0];
        next_st.nackLast = pwdata[CMD_NACK_LAST];
        next_st.busy = 1'b1;
      end else if (paddr == TX_OFF) begin
        next_st.tx = pwdata[7:0];
      end
    end
    case (st.phase)
      H_IDLE: begin
        next_st.sdaOe = 1'b0; // RULE2
        if (st.busy) begin
          next_st.tick = 3'h0;
          next_st.q = 2'h0;
          next_st.bitIdx = 4'h0;
          next_st.txShift = st.tx;
          if (st.pend[CMD_START]) begin
            next_st.phase = H_START; // RULE1
            next_st.pend[CMD_START] = 1'b0;
            next_st.scl = 1'b0;
          end else if (st.pend[CMD_WRITE]) begin
            next_st.phase = H_BIT;
            next_st.rd = 1'b0; // RULE16
            next_st.pend[CMD_WRITE] = 1'b0;
            next_st.scl = 1'b0;
          end else if (st.pend[CMD_READ]) begin
            next_st.phase = H_BIT;
            next_st.rd = 1'b1;
            next_st.pend[CMD_READ] = 1'b0;
            next_st.scl = 1'b0;
          end else if (st.pend[CMD_STOP]) begin
            next_st.phase = H_STOP;
            next_st.pend[CMD_STOP] = 1'b0;
            next_st.scl = 1'b0;
          end else begin
            next_st.busy = 1'b0;
          end
        end
      end
      H_START, H_BIT, H_STOP: begin
        next_st.tick = st.tick + 3'h1;
        if (st.tick == QUARTER_LAST) begin
          next_st.tick = 3'h0;
          next_st.q = nq;
          next_st.scl = nq[1]; // RULE7
          if (nq == Q_LOW_SET || (nq == Q_HIGH_SET && st.phase != H_BIT)) begin
            next_st.sdaOe = ~bitVal; // RULE3 RULE7
          end
          if (st.q == Q_HIGH_SET) begin
            next_st.phase = H_IDLE;
            if (st.phase == H_BIT) begin
              if (st.bitIdx == BYTE_BITS) begin
                if (!st.rd) begin
                  next_st.nack = st.sdaSync; // RULE9
                end
              end else begin
                next_st.phase = H_BIT; // RULE8
                next_st.bitIdx = st.bitIdx + 4'h1;
                next_st.txShift = {st.txShift[6:0], 1'b0};
                next_st.rx = {st.rx[6:0], st.sdaSync}; // RULE7
              end
            end
            // scl rests low between bytes, high only after reset or once a stop is done
            next_st.scl = (st.phase == H_STOP); // RULE5
          end
        end
      end
      default: begin
        next_st.phase = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
      st.scl <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign link.scl = st.scl;
  assign link.sdaHostOut = DRIVE_LOW;
  assign link.sdaHostOe = st.sdaOe;
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
endmodule : rtcsp_host

// ### verilog/rtcsp_pkg.sv
package rtcsp_pkg;
  // control byte
  localparam logic [3:0] CODE_EEPROM         = 4'ha;
  localparam logic [3:0] CODE_CLOCK          = 4'hd;
  localparam logic [2:0] CHIP_SELECT         = 3'h7;
  localparam logic [3:0] BYTE_BITS           = 4'h8;
  // clock/sram space: clock_calendar_registers then user sram
  localparam logic [7:0] CLOCK_REG_LAST      = 8'h1f;
  localparam logic [7:0] SRAM_FIRST          = 8'h20;
  localparam logic [7:0] SRAM_LAST           = 8'h5f;
  localparam int         CLOCK_SPACE_BYTES   = 96;
  // eeprom space
  localparam logic [7:0] EEPROM_LAST         = 8'h7f;
  localparam logic [7:0] PROT_FIRST          = 8'hf0;
  localparam logic [7:0] PROT_LAST           = 8'hf7;
  localparam logic [7:0] PROTECT_STATUS_ADDR = 8'hff;
  localparam int         EEPROM_SPACE_BYTES  = 137;
  localparam logic [7:0] PROT_INDEX          = 8'h80;
  localparam logic [7:0] STATUS_INDEX        = 8'h88;
  localparam logic [7:0] UNMAPPED_READ       = 8'hff;
  localparam logic       DRIVE_LOW           = 1'b0;
  // host timing: one scl period is four quarters
  localparam int         QUARTER_CYCLES      = 8;
  localparam logic [2:0] QUARTER_LAST        = 3'(QUARTER_CYCLES - 1);
  localparam logic [1:0] Q_LOW_SET           = 2'h1;
  localparam logic [1:0] Q_HIGH_SET          = 2'h3;
  // host apb registers
  localparam logic [7:0] CMD_OFF             = 8'h00;
  localparam logic [7:0] TX_OFF              = 8'h04;
  localparam logic [7:0] RX_OFF              = 8'h08;
  localparam logic [7:0] STAT_OFF            = 8'h0c;
  localparam int         CMD_START           = 0;
  localparam int         CMD_WRITE           = 1;
  localparam int         CMD_READ            = 2;
  localparam int         CMD_STOP            = 3;
  localparam int         CMD_NACK_LAST       = 4;
  localparam int         STAT_BUSY           = 0;
  localparam int         STAT_NACK           = 1;

  typedef enum logic [2:0] {
    D_IDLE, D_CTRL, D_ADDR, D_WDATA, D_ACK, D_RDATA, D_MACK, D_IGNORE
  } rtcsp_dev_state_type;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} rtcsp_host_phase_type;
endpackage : rtcsp_pkg
